// file: verilog/ts_out_pkg.sv
// Shared constants and types for the serial transport stream output
`default_nettype none
package ts_out_pkg;

    // Packet framing: data bytes, then the redundancy bytes that follow them
    localparam int PKT_BYTES = 188;
    localparam int RED_BYTES_DEF = 20;
    localparam int BYTE_BITS = 8;
    localparam int IDX_W = 8;

    // Bit position limits inside a byte, MSB leaves first
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int MSB_POS = 7;

    // Reset values of the logical output levels
    localparam logic LEVEL_IDLE = 1'h0;
    localparam logic [7:0] BYTE_IDLE = 8'h00;

    // Synchroniser depth for every control and option crossing; the mailbox data is read directly, not synchronised
    localparam int SYNC_STAGES = 2;

    // Polarity and edge options, quasi-static
    typedef struct packed {
        logic clk_inv;
        logic start_inv;
        logic gate_inv;
        logic err_inv;
        logic edge_rise;
    } pol_cfg_t;

    localparam int POL_CFG_W = $bits(pol_cfg_t);

    // One byte on its way to the link with its framing flags
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic payload;
        logic err;
    } lane_t;

    // Source side handshake states
    typedef enum logic [1:0] {
        SRC_FREE = 2'b01,
        SRC_WAIT = 2'b10
    } src_state_t;

    // Link side serializer states
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SHIFT = 2'b10
    } ser_state_t;

    // Active level to pin level under a polarity option
    function automatic logic drive_pin(input logic active, input logic inv);
        drive_pin = active ^ inv;
    endfunction

endpackage
`default_nettype wire

// file: verilog/sync_cell.sv
// Two-flop level synchroniser with asynchronous reset to zero
`default_nettype none
`timescale 1ns/10ps
module sync_cell #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [W-1:0] d, // Level from another domain
    output logic [W-1:0] q // Synchronised level
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_regs_t;

    sync_regs_t s_r;
    sync_regs_t s_nxt;

    // First stage feeds only the second stage
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;

endmodule
`default_nettype wire

// file: verilog/ts_serial_out.sv
// Serial transport stream output with redundancy bytes, two clock domains
`default_nettype none
`timescale 1ns/10ps
// Contract
// - Bit clock, start marker, payload gate and error flag polarities set separately.
// - All stream outputs change on one chosen bit-clock edge, falling by default.
// - Start marker active exactly eight bit cycles, over the first byte's bits.
// - Payload gate active for the 188 data bytes only, never for redundancy.
// - Errored packet keeps the error flag active over its 188 data bytes, not over its redundancy bytes.
// - Packets are framed as 188 data bytes plus RED_BYTES redundancy bytes for marker and error window.
// - Stream leaves on one serial data line, valid against the chosen edge.
module ts_serial_out #(
    parameter int RED_BYTES = ts_out_pkg::RED_BYTES_DEF
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic link_clk, // Link clock, twice the bit rate
    input wire logic [7:0] in_data, // Byte from the decoder
    input wire logic in_valid, // Byte offered
    input wire logic in_sop, // Byte is first of a packet
    input wire logic in_err, // Packet uncorrectable, read with in_sop
    output logic in_ready, // Byte can be taken
    input wire ts_out_pkg::pol_cfg_t pol_cfg, // Polarity and edge options
    output logic underrun, // Sticky: source fell behind mid-packet
    output logic stream_bit_clock, // Output bit clock pin
    output logic serial_stream_out, // Serial data pin
    output logic packet_start_marker, // First byte marker pin
    output logic payload_window_gate, // Data byte window pin
    output logic packet_error_flag // Packet error pin
);

    // Framing limits sized to the index counter
    localparam logic [7:0] PKT_LAST = 8'(ts_out_pkg::PKT_BYTES - 1);
    localparam logic [7:0] FRAME_LAST = 8'(ts_out_pkg::PKT_BYTES + RED_BYTES - 1);
    localparam logic [7:0] IDX_ZERO = 8'h00;
    localparam logic [7:0] IDX_ONE = 8'h01;

    // Source domain state
    typedef struct packed {
        ts_out_pkg::src_state_t st;
        ts_out_pkg::lane_t mbox;
        logic req;
        logic free;
        logic [7:0] idx;
        logic perr;
        logic underrun;
    } src_regs_t;

    // Link domain state
    typedef struct packed {
        ts_out_pkg::ser_state_t st;
        ts_out_pkg::lane_t hold;
        logic hold_full;
        logic req_seen;
        logic [7:0] shreg;
        logic [2:0] bit_cnt;
        logic [7:0] left;
        logic underrun;
        logic phase;
        logic first_a;
        logic payload_a;
        logic err_a;
        logic bclk_pin;
        logic sdo_pin;
        logic start_pin;
        logic gate_pin;
        logic err_pin;
    } link_regs_t;

    src_regs_t src_r;
    src_regs_t src_nxt;
    link_regs_t link_r;
    link_regs_t link_nxt;

    logic link_rst_n;
    logic req_sync;
    logic ack_sync;
    logic underrun_sync;
    ts_out_pkg::pol_cfg_t cfg_sync;
    logic [ts_out_pkg::POL_CFG_W-1:0] cfg_sync_bits;

    // Link reset: asserts at once, releases on the link clock
    sync_cell #(.W(1)) u_link_rst (
        .clk(link_clk),
        .reset_n(reset_n),
        .d(1'h1),
        .q(link_rst_n)
    );

    // Request toggle into the link domain
    sync_cell #(.W(1)) u_req_sync (
        .clk(link_clk),
        .reset_n(link_rst_n),
        .d(src_r.req),
        .q(req_sync)
    );

    // Options are static in use, so a level sync per bit is enough
    sync_cell #(.W(ts_out_pkg::POL_CFG_W)) u_cfg_sync (
        .clk(link_clk),
        .reset_n(link_rst_n),
        .d(pol_cfg),
        .q(cfg_sync_bits)
    );

    assign cfg_sync = ts_out_pkg::pol_cfg_t'(cfg_sync_bits);

    // Acknowledge toggle back to the source domain
    sync_cell #(.W(1)) u_ack_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(link_r.req_seen),
        .q(ack_sync)
    );

    // Sticky underrun level back to the source domain
    sync_cell #(.W(1)) u_und_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(link_r.underrun),
        .q(underrun_sync)
    );

    // Source side: frame the byte, fill the mailbox, toggle the request
    always_comb begin
        logic [7:0] idx_eff;
        logic is_first;
        logic is_payload;
        logic pkt_err;
        idx_eff = src_r.idx;
        is_first = 1'h0;
        is_payload = 1'h0;
        pkt_err = src_r.perr;
        src_nxt = src_r;
        src_nxt.underrun = underrun_sync;
        // A marked first byte restarts framing even mid-packet
        if (in_sop) begin
            idx_eff = IDX_ZERO;
        end
        is_first = (idx_eff == IDX_ZERO);
        is_payload = (idx_eff <= PKT_LAST);
        if (is_first) begin
            pkt_err = in_err;
        end
        unique case (src_r.st)
            ts_out_pkg::SRC_FREE: begin
                if (in_valid) begin
                    src_nxt.mbox.data = in_data;
                    src_nxt.mbox.first = is_first;
                    src_nxt.mbox.payload = is_payload;
                    src_nxt.mbox.err = pkt_err && is_payload;
                    src_nxt.perr = pkt_err;
                    if (idx_eff == FRAME_LAST) begin
                        src_nxt.idx = IDX_ZERO;
                    end else begin
                        src_nxt.idx = idx_eff + IDX_ONE;
                    end
                    src_nxt.req = ~src_r.req;
                    src_nxt.free = 1'h0;
                    src_nxt.st = ts_out_pkg::SRC_WAIT;
                end
            end
            ts_out_pkg::SRC_WAIT: begin
                // Mailbox stays frozen until the link has copied it
                if (ack_sync == src_r.req) begin
                    src_nxt.free = 1'h1;
                    src_nxt.st = ts_out_pkg::SRC_FREE;
                end
            end
            default: begin
                src_nxt.st = ts_out_pkg::SRC_FREE;
                src_nxt.free = (ack_sync == src_r.req);
            end
        endcase
    end

    // Source domain register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_r <= '{st: ts_out_pkg::SRC_FREE, mbox: '0, req: 1'h0, free: 1'h1,
                       idx: IDX_ZERO, perr: 1'h0, underrun: 1'h0};
        end else begin
            src_r <= src_nxt;
        end
    end

    // Link side: take the mailbox, run the bit clock, shift the bytes
    always_comb begin
        logic tick;
        logic byte_done;
        link_nxt = link_r;
        tick = 1'h0;
        byte_done = 1'h0;
        // Bit clock is half the link clock, 50 percent duty
        link_nxt.phase = ~link_r.phase;
        link_nxt.bclk_pin = ts_out_pkg::drive_pin(link_nxt.phase, cfg_sync.clk_inv);
        tick = (link_nxt.phase == cfg_sync.edge_rise);
        // Copy a new mailbox word only into an empty holding slot
        if (req_sync != link_r.req_seen && !link_r.hold_full) begin
            link_nxt.hold = src_r.mbox;
            link_nxt.hold_full = 1'h1;
            link_nxt.req_seen = req_sync;
        end
        byte_done = (link_r.st != ts_out_pkg::SER_SHIFT) || (link_r.bit_cnt == ts_out_pkg::LAST_BIT);
        if (tick) begin
            if (!byte_done) begin
                link_nxt.shreg = {link_r.shreg[6:0], 1'h0};
                link_nxt.bit_cnt = link_r.bit_cnt + 3'h1;
            end else if (link_r.hold_full) begin
                link_nxt.shreg = link_r.hold.data;
                link_nxt.bit_cnt = ts_out_pkg::FIRST_BIT;
                link_nxt.first_a = link_r.hold.first;
                link_nxt.payload_a = link_r.hold.payload;
                link_nxt.err_a = link_r.hold.err;
                link_nxt.hold_full = 1'h0;
                link_nxt.st = ts_out_pkg::SER_SHIFT;
                if (link_r.hold.first) begin
                    link_nxt.left = FRAME_LAST;
                end else if (link_r.left != IDX_ZERO) begin
                    link_nxt.left = link_r.left - IDX_ONE;
                end
            end else begin
                // Nothing to send: flags drop, data line rests low
                link_nxt.st = ts_out_pkg::SER_IDLE;
                link_nxt.shreg = ts_out_pkg::BYTE_IDLE;
                link_nxt.first_a = ts_out_pkg::LEVEL_IDLE;
                link_nxt.payload_a = ts_out_pkg::LEVEL_IDLE;
                link_nxt.err_a = ts_out_pkg::LEVEL_IDLE;
                // A packet cut short is remembered until reset
                if (link_r.left != IDX_ZERO) begin
                    link_nxt.underrun = 1'h1;
                    link_nxt.left = IDX_ZERO;
                end
            end
            link_nxt.sdo_pin = link_nxt.shreg[ts_out_pkg::MSB_POS];
            link_nxt.start_pin = ts_out_pkg::drive_pin(link_nxt.first_a, cfg_sync.start_inv);
            link_nxt.gate_pin = ts_out_pkg::drive_pin(link_nxt.payload_a, cfg_sync.gate_inv);
            link_nxt.err_pin = ts_out_pkg::drive_pin(link_nxt.err_a, cfg_sync.err_inv);
        end
    end

    // Link domain register, pins come straight from here
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_r <= '{st: ts_out_pkg::SER_IDLE, hold: '0, hold_full: 1'h0, req_seen: 1'h0,
                        shreg: ts_out_pkg::BYTE_IDLE, bit_cnt: ts_out_pkg::FIRST_BIT,
                        left: IDX_ZERO, underrun: 1'h0, phase: 1'h0,
                        first_a: 1'h0, payload_a: 1'h0, err_a: 1'h0,
                        bclk_pin: 1'h0, sdo_pin: 1'h0, start_pin: 1'h0,
                        gate_pin: 1'h0, err_pin: 1'h0};
        end else begin
            link_r <= link_nxt;
        end
    end

    // Outputs, each straight from a flop
    assign in_ready = src_r.free;
    assign underrun = src_r.underrun;
    assign stream_bit_clock = link_r.bclk_pin;
    assign serial_stream_out = link_r.sdo_pin;
    assign packet_start_marker = link_r.start_pin;
    assign payload_window_gate = link_r.gate_pin;
    assign packet_error_flag = link_r.err_pin;

endmodule
`default_nettype wire

// file: test/ts_serial_out_assertions.sv
// Concurrent checks on the serial stream pins of the output block
`timescale 1ns/10ps
`default_nettype none
module ts_serial_out_assertions #(
    parameter int RED_BYTES = 20
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic link_clk, // Link clock
    input wire ts_out_pkg::pol_cfg_t pol_cfg, // Polarity and edge options
    input wire logic stream_bit_clock, // Bit clock pin
    input wire logic serial_stream_out, // Data pin
    input wire logic packet_start_marker, // Start pin
    input wire logic payload_window_gate, // Gate pin
    input wire logic packet_error_flag // Error pin
);
    logic st_a, gt_a, er_a, tick, en;
    logic [3:0] live_r;
    logic [4:0] st_cnt_r;
    logic [11:0] gt_cnt_r, lo_cnt_r;
    // Active levels with polarity removed; tick marks the launch edge
    assign st_a = packet_start_marker ^ pol_cfg.start_inv;
    assign gt_a = payload_window_gate ^ pol_cfg.gate_inv;
    assign er_a = packet_error_flag ^ pol_cfg.err_inv;
    assign tick = (stream_bit_clock ^ pol_cfg.clk_inv) == pol_cfg.edge_rise;
    assign en = live_r == 4'hf;
    // Run lengths; checks wait until the options have reached the link
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_r <= 4'h0;
            st_cnt_r <= 5'h00;
            gt_cnt_r <= 12'h000;
            lo_cnt_r <= 12'hfff;
        end else begin
            live_r <= en ? live_r : live_r + 4'h1;
            st_cnt_r <= st_a ? st_cnt_r + 5'h01 : 5'h00;
            gt_cnt_r <= gt_a ? gt_cnt_r + 12'h001 : 12'h000;
            lo_cnt_r <= (gt_a && en) ? 12'h000 : lo_cnt_r + {11'h0, lo_cnt_r != 12'hfff};
        end
    end
    default clocking @(posedge link_clk);
    endclocking
    default disable iff (!reset_n || !en);
    sequence s_open;
        $rose(gt_a) && st_a;
    endsequence
    chk_pins_on_tick: assert property (!tick |-> $stable({serial_stream_out, st_a, gt_a, er_a}))
        else $error("stream pins moved off the launch edge");
    chk_clock_toggle: assert property ($changed(stream_bit_clock))
        else $error("bit clock missed a half period");
    chk_start_len: assert property ($fell(st_a) |-> st_cnt_r == 5'h10)
        else $error("start marker not sixteen link cycles");
    chk_first_byte: assert property (s_open |-> ##15 (st_a && gt_a) ##1 (!st_a && gt_a))
        else $error("first byte framing wrong");
    chk_start_in_gate: assert property (st_a |-> gt_a)
        else $error("start marker outside payload window");
    chk_gate_len: assert property ($fell(gt_a) |-> gt_cnt_r == 12'hbc0)
        else $error("payload window not 188 bytes long");
    chk_red_gap: assert property ($rose(gt_a) |-> lo_cnt_r >= RED_BYTES * 16)
        else $error("payload window open over redundancy");
    chk_err_in_gate: assert property (er_a |-> gt_a)
        else $error("error flag outside payload window");
    chk_err_steady: assert property (gt_a && $past(gt_a) |-> $stable(er_a))
        else $error("error flag changed inside a packet");
endmodule
bind ts_serial_out ts_serial_out_assertions #(.RED_BYTES(RED_BYTES)) u_chk (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .pol_cfg(pol_cfg),
    .stream_bit_clock(stream_bit_clock), .serial_stream_out(serial_stream_out),
    .packet_start_marker(packet_start_marker), .payload_window_gate(payload_window_gate),
    .packet_error_flag(packet_error_flag));
`default_nettype wire

// file: test/ts_stream_sink.sv
// Downstream demultiplexer model rebuilding bytes from the serial pins
`timescale 1ns/10ps
`default_nettype none
module ts_stream_sink (
    input wire logic link_clk, // Link clock
    input wire logic reset_n, // Async reset, active low
    input wire ts_out_pkg::pol_cfg_t pol_cfg, // Polarity options
    input wire logic bit_clk, // Bit clock pin
    input wire logic sdo, // Data pin
    input wire logic start, // Start pin
    input wire logic gate, // Gate pin
    input wire logic err // Error pin
);
    logic [9:0] got_q[$];
    logic [7:0] sh;
    logic fst;
    int n;
    // Sample opposite the launch edge, where each bit has settled
    always @(posedge link_clk) begin
        if (!reset_n || !(gate ^ pol_cfg.gate_inv)) begin
            n = 0;
        end else if ((bit_clk ^ pol_cfg.clk_inv) != pol_cfg.edge_rise) begin
            if (n == 0) begin
                fst = start ^ pol_cfg.start_inv;
            end
            sh = {sh[6:0], sdo};
            n = n + 1;
            if (n == 8) begin
                got_q.push_back({err ^ pol_cfg.err_inv, fst, sh});
                n = 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/ts_serial_out_redundancy_tb.sv
// Testbench: random packets under each polarity set, checked byte by byte
`timescale 1ns/10ps
`default_nettype none
module ts_serial_out_redundancy_tb;
    localparam int RED = 4;
    logic clk, link_clk, reset_n, in_valid, in_sop, in_err, in_ready, underrun;
    logic [7:0] in_data;
    ts_out_pkg::pol_cfg_t pol_cfg;
    logic bclk, sdo, st, gt, er;
    int mismatches, num_checks, cyc;
    int exp_q[$];
    logic [4:0] cfgs[4] = '{5'h00, 5'h1f, 5'h0a, 5'h15};
    ts_serial_out #(.RED_BYTES(RED)) u_dut (
        .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .in_data(in_data),
        .in_valid(in_valid), .in_sop(in_sop), .in_err(in_err), .in_ready(in_ready),
        .pol_cfg(pol_cfg), .underrun(underrun), .stream_bit_clock(bclk),
        .serial_stream_out(sdo), .packet_start_marker(st), .payload_window_gate(gt),
        .packet_error_flag(er));
    ts_stream_sink u_sink (
        .link_clk(link_clk), .reset_n(reset_n), .pol_cfg(pol_cfg), .bit_clk(bclk),
        .sdo(sdo), .start(st), .gate(gt), .err(er));
    // Two unrelated clocks
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One packet back to back; error only honoured on the first byte
    task automatic send_pkt(input logic e, input int len);
        logic [7:0] d;
        for (int i = 0; i < len; i++) begin
            d = 8'($urandom);
            in_data <= d;
            in_sop <= (i == 0);
            in_err <= (i == 0) ? e : 1'($urandom);
            in_valid <= 1'b1;
            do @(posedge clk); while (in_ready !== 1'b1);
            if (i < 188) begin
                exp_q.push_back(int'({e, i == 0, d}));
            end
        end
    endtask
    // Rebuilt bytes are matched against the model as they arrive
    always @(posedge link_clk) begin
        if (u_sink.got_q.size() > 0) begin
            check(32'(u_sink.got_q.pop_front()), exp_q.pop_front());
        end
    end
    // Hang guard: the whole run needs roughly 13000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h468d));
        reset_n = 1'b0;
        in_valid = 1'b0;
        in_sop = 1'b0;
        in_err = 1'b0;
        in_data = 8'h00;
        pol_cfg = 5'h00;
        repeat (12) @(posedge clk);
        // Options change only under reset, since they cross as levels
        for (int c = 0; c < 5; c++) begin
            pol_cfg <= (c < 4) ? cfgs[c] : 5'($urandom);
            reset_n <= 1'b0;
            repeat (4) @(posedge clk);
            reset_n <= 1'b1;
            @(posedge clk);
            send_pkt(1'($urandom), 188 + RED);
            send_pkt(1'b1, 188 + RED);
            in_valid <= 1'b0;
            for (int w = 0; w < 2000 && exp_q.size() > 0; w++) @(posedge clk);
            repeat (60) @(posedge clk);
            check(exp_q.size(), 0);
            check(32'(underrun), 0);
        end
        // Packet cut after its data bytes: redundancy missing, underrun must latch
        send_pkt(1'($urandom), 188);
        in_valid <= 1'b0;
        for (int w = 0; w < 2000 && exp_q.size() > 0; w++) @(posedge clk);
        repeat (60) @(posedge clk);
        check(exp_q.size(), 0);
        check(32'(underrun), 1);
        check(32'(in_ready), 1);
        summarize();
    end
endmodule
`default_nettype wire
